// >>> rtl/uds_top.sv
// Behaviour
// - all ports but the asynchronous reset presetn change and are sampled on the rising clock edge only.
// - 32-bit sample sink, ready latency one, one sample per cycle possible.
// - sample low 16 bits real, next 16 bits imaginary.
// - sample inputs are ignored while sample valid is low.
// - 41-bit ranging map sink, same handshake, either side may stall.
// - ranging word fields header, antenna, channel, type, first, last, slot.
// - ranging type codes 2-sym, 4-sym initial; 1-sym, 3-sym periodic.
// - starting slot belongs to lowest subchannel of the ranging channel.
// - ranging packet of 1-12 words per group; header 11 ends it.
// - extraction waits for first map word of its group.
// - ranging first subchannel 127 means no ranging channels.
// - 35-bit user map sink with header, antenna, first, last, slot fields.
// - user word allocates first to last subchannel inclusive.
// - user packet of 1-70 words per group; header 11 ends it.
// - user words may describe non-adjacent ranges.
// - user first subchannel 127 means no user extraction.
// - six-symbol double buffer; group handled once three symbols stored.
module uds_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic din_valid,
   input wire logic [31:0] din_data,
   output logic din_ready,
   input wire logic rmapin_valid,
   input wire logic [40:0] rmapin_data,
   output logic rmapin_ready,
   input wire logic dmapin_valid,
   input wire logic [34:0] dmapin_data,
   output logic dmapin_ready,
   input wire logic [6:0] cell_identity_a,
   input wire logic [6:0] cell_identity_b
);
   logic rm_valid, dm_valid, rm_pop, dm_pop;
   logic [40:0] rm_word, dm_word;
   logic [34:0] dm_raw;
   logic grp_ready, rel;
   logic [31:0] rd_data, last_sample;

   uds_map_sink #(.W(41)) u_rmap (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(rmapin_valid),
      .in_data(rmapin_data),
      .in_ready(rmapin_ready),
      .pop(rm_pop),
      .out_valid(rm_valid),
      .out_word(rm_word)
   );

   uds_map_sink #(.W(35)) u_dmap (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(dmapin_valid),
      .in_data(dmapin_data),
      .in_ready(dmapin_ready),
      .pop(dm_pop),
      .out_valid(dm_valid),
      .out_word(dm_raw)
   );
   assign dm_word = {6'd0, dm_raw};

   logic [9:0] saddr_r, saddr_nxt;

   uds_sample_store u_store (
      .pclk(pclk),
      .presetn(presetn),
      .din_valid(din_valid),
      .din_data(din_data),
      .din_ready(din_ready),
      .release_grp(rel),
      .group_ready(grp_ready),
      .rd_addr(saddr_r),
      .rd_data(rd_data),
      .last_sample(last_sample)
   );

   // map word fields
   logic [6:0] r_first, r_last, u_first, u_last;
   logic [2:0] r_ant, u_ant;
   logic [3:0] r_ch;
   logic [7:0] u_span;
   logic r_empty, u_empty;
   always_comb begin
      r_first = uds_pkg::fld7(rm_word, uds_pkg::R_FIRST_LSB);
      r_last = uds_pkg::fld7(rm_word, uds_pkg::R_LAST_LSB);
      u_first = uds_pkg::fld7(dm_word, uds_pkg::U_FIRST_LSB);
      u_last = uds_pkg::fld7(dm_word, uds_pkg::U_LAST_LSB);
      r_ant = rm_word[uds_pkg::ANT_LSB +: 3];
      u_ant = dm_word[uds_pkg::ANT_LSB +: 3];
      r_ch = rm_word[uds_pkg::R_CH_LSB +: 4];
      r_empty = r_first == uds_pkg::SUB_EMPTY;
      u_empty = u_first == uds_pkg::SUB_EMPTY;
      u_span = {1'b0, u_last} - {1'b0, u_first} + 8'd1;
   end

   // group walk state
   uds_pkg::uds_state_t st_r, st_nxt;
   logic en_r, en_nxt;
   logic [2:0] ant_r, ant_nxt;
   logic [3:0] rcnt_r, rcnt_nxt, rlast_r, rlast_nxt;
   logic [7:0] ucnt_r, ucnt_nxt, ulast_r, ulast_nxt;
   logic [15:0] groups_r, groups_nxt;
   logic [15:0] rslot_r, rslot_nxt, uslot_r, uslot_nxt;
   uds_pkg::uds_rtype_t rtype_r, rtype_nxt;
   logic ant_set, fmt_set;

   always_comb begin
      st_nxt = st_r;
      rm_pop = 1'b0;
      dm_pop = 1'b0;
      rel = 1'b0;
      ant_nxt = ant_r;
      rcnt_nxt = rcnt_r;
      ucnt_nxt = ucnt_r;
      rlast_nxt = rlast_r;
      ulast_nxt = ulast_r;
      groups_nxt = groups_r;
      rslot_nxt = rslot_r;
      uslot_nxt = uslot_r;
      rtype_nxt = rtype_r;
      ant_set = 1'b0;
      fmt_set = 1'b0;
      case (st_r)
         uds_pkg::ST_WAIT: begin
            // full group of three symbols and both first map words present
            if (en_r && grp_ready && rm_valid && dm_valid) begin
               st_nxt = uds_pkg::ST_RANG;
               ant_nxt = r_ant;
               rcnt_nxt = 4'd0;
               ucnt_nxt = 8'd0;
            end
         end
         uds_pkg::ST_RANG: begin
            if (rm_valid) begin
               rm_pop = 1'b1;
               ant_set = r_ant != ant_r;
               if (!r_empty) begin
                  rcnt_nxt = rcnt_r + 4'd1;
                  rtype_nxt = uds_pkg::uds_rtype_t'(rm_word[uds_pkg::R_TYPE_LSB +: 2]);
                  if (rcnt_r == 4'd0) rslot_nxt = rm_word[uds_pkg::R_SLOT_LSB +: 16];
                  fmt_set = r_ch > uds_pkg::RANG_CH_MAX
                     || r_last - r_first != 7'({3'd0, uds_pkg::RANG_SUBCH} - 7'd1);
               end
               if (uds_pkg::is_last(rm_word)) st_nxt = uds_pkg::ST_USER;
            end
         end
         uds_pkg::ST_USER: begin
            if (dm_valid) begin
               dm_pop = 1'b1;
               ant_set = u_ant != ant_r;
               // each word is its own range, gaps between words allowed
               if (!u_empty) begin
                  ucnt_nxt = ucnt_r + u_span;
                  if (ucnt_r == 8'd0) uslot_nxt = dm_word[uds_pkg::U_SLOT_LSB +: 16];
                  fmt_set = u_last < u_first;
               end
               if (uds_pkg::is_last(dm_word)) st_nxt = uds_pkg::ST_FREE;
            end
         end
         uds_pkg::ST_FREE: begin
            rel = 1'b1;
            groups_nxt = groups_r + 16'd1;
            rlast_nxt = rcnt_r;
            ulast_nxt = ucnt_r;
            st_nxt = uds_pkg::ST_WAIT;
         end
         default: st_nxt = uds_pkg::ST_WAIT;
      endcase
   end

   // apb slave: zero wait, answer in the access cycle
   logic rdy_r, rdy_nxt, err_r, err_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic antf_r, antf_nxt, fmtf_r, fmtf_nxt;
   logic wr, setup;
   always_comb begin
      setup = psel && !penable;
      wr = psel && penable && rdy_r && pwrite;
      rdy_nxt = setup;
      err_nxt = 1'b0;
      rd_nxt = rd_r;
      en_nxt = en_r;
      saddr_nxt = saddr_r;
      if (setup) begin
         rd_nxt = 32'h0;
         case (paddr)
            uds_pkg::REG_CTRL: rd_nxt = {31'h0, en_r};
            uds_pkg::REG_STATUS: rd_nxt = {26'h0, fmtf_r, antf_r, st_r, grp_ready, din_ready};
            uds_pkg::REG_GROUPS: rd_nxt = {16'h0, groups_r};
            uds_pkg::REG_RANG: rd_nxt = {rslot_r, 10'h0, rtype_r, rlast_r};
            uds_pkg::REG_USER: rd_nxt = {uslot_r, 8'h0, ulast_r};
            uds_pkg::REG_SADDR: rd_nxt = {22'h0, saddr_r};
            uds_pkg::REG_SDATA: rd_nxt = rd_data;
            // mismatch flag: both identity inputs should agree
            uds_pkg::REG_CELL: rd_nxt = {16'h0, cell_identity_a != cell_identity_b,
                                         cell_identity_b, 1'b0, cell_identity_a};
            uds_pkg::REG_LAST: rd_nxt = last_sample;
            default: err_nxt = 1'b1;
         endcase
      end
      if (wr && paddr == uds_pkg::REG_CTRL) en_nxt = pwdata[0];
      if (wr && paddr == uds_pkg::REG_SADDR) saddr_nxt = pwdata[9:0];
      // write one to clear; a new event in the same cycle wins
      antf_nxt = ant_set || (antf_r && !(wr && paddr == uds_pkg::REG_STATUS && pwdata[uds_pkg::ST_ANT_ERR]));
      fmtf_nxt = fmt_set || (fmtf_r && !(wr && paddr == uds_pkg::REG_STATUS && pwdata[uds_pkg::ST_FMT_ERR]));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= uds_pkg::ST_WAIT;
         en_r <= uds_pkg::CTRL_RST;
         ant_r <= 3'd0;
         rcnt_r <= 4'd0;
         ucnt_r <= 8'd0;
         rlast_r <= 4'd0;
         ulast_r <= 8'd0;
         groups_r <= 16'h0;
         rslot_r <= 16'h0;
         uslot_r <= 16'h0;
         rtype_r <= uds_pkg::RT_INIT_2SYM;
         rdy_r <= 1'b0;
         err_r <= 1'b0;
         rd_r <= 32'h0;
         antf_r <= 1'b0;
         fmtf_r <= 1'b0;
         saddr_r <= 10'd0;
      end else begin
         st_r <= st_nxt;
         en_r <= en_nxt;
         ant_r <= ant_nxt;
         rcnt_r <= rcnt_nxt;
         ucnt_r <= ucnt_nxt;
         rlast_r <= rlast_nxt;
         ulast_r <= ulast_nxt;
         groups_r <= groups_nxt;
         rslot_r <= rslot_nxt;
         uslot_r <= uslot_nxt;
         rtype_r <= rtype_nxt;
         rdy_r <= rdy_nxt;
         err_r <= err_nxt;
         rd_r <= rd_nxt;
         antf_r <= antf_nxt;
         fmtf_r <= fmtf_nxt;
         saddr_r <= saddr_nxt;
      end
   end

   assign prdata = rd_r;
   assign pready = rdy_r;
   assign pslverr = err_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_start;
      st_r == uds_pkg::ST_WAIT && st_nxt == uds_pkg::ST_RANG;
   endsequence
   sequence s_rlast;
      st_r == uds_pkg::ST_RANG && rm_pop && uds_pkg::is_last(rm_word);
   endsequence

   a_start_gate: assert property (s_start |-> grp_ready && rm_valid && dm_valid)
      else $error("group started without map word or data");
   a_group_full: assert property (s_start |-> u_store.count_r >= uds_pkg::GROUP_WORDS)
      else $error("group started before three symbols");
   a_rang_end: assert property (s_rlast |=> st_r == uds_pkg::ST_USER)
      else $error("ranging packet end missed");
   a_rang_empty: assert property ((st_r == uds_pkg::ST_RANG && rm_pop && r_empty) |=> rcnt_r == $past(rcnt_r))
      else $error("empty ranging word counted");
   a_user_span: assert property ((st_r == uds_pkg::ST_USER && dm_pop && !u_empty)
      |=> ucnt_r == $past(ucnt_r) + $past(u_last) - $past(u_first) + 8'd1)
      else $error("user range not inclusive");
   a_user_empty: assert property ((st_r == uds_pkg::ST_USER && dm_pop && u_empty) |=> ucnt_r == $past(ucnt_r))
      else $error("empty user word counted");
   a_free_release: assert property ((st_r == uds_pkg::ST_USER && dm_pop && uds_pkg::is_last(dm_word))
      |=> rel ##1 st_r == uds_pkg::ST_WAIT)
      else $error("group not released after user packet");
   a_apb_answer: assert property ((psel && !penable) |=> pready ##1 !pready)
      else $error("apb answer not one cycle");
endmodule : uds_top

// >>> rtl/uds_pkg.sv
package uds_pkg;
   localparam int N_FFT = 128;
   localparam logic [10:0] GROUP_WORDS = 11'd384;
   localparam logic [10:0] STORE_WORDS = 11'd768;
   localparam logic [9:0] STORE_LAST = 10'd767;
   localparam logic [3:0] RANG_SUBCH = (N_FFT == 128) ? 4'd4 : 4'd6;
   localparam logic [3:0] RANG_CH_MAX = 4'd11;

   localparam int HDR_LSB = 0;
   localparam int ANT_LSB = 2;
   localparam int R_CH_LSB = 5;
   localparam int R_TYPE_LSB = 9;
   localparam int R_FIRST_LSB = 11;
   localparam int R_LAST_LSB = 18;
   localparam int R_SLOT_LSB = 25;
   localparam int U_FIRST_LSB = 5;
   localparam int U_LAST_LSB = 12;
   localparam int U_SLOT_LSB = 19;
   localparam logic [1:0] HDR_LAST = 2'h3;
   localparam logic [6:0] SUB_EMPTY = 7'h7f;

   typedef enum logic [1:0] {
      RT_INIT_2SYM = 2'b00,
      RT_INIT_4SYM = 2'b01,
      RT_PER_1SYM = 2'b10,
      RT_PER_3SYM = 2'b11
   } uds_rtype_t;

   typedef enum logic [1:0] {
      ST_WAIT = 2'b00,
      ST_RANG = 2'b01,
      ST_USER = 2'b10,
      ST_FREE = 2'b11
   } uds_state_t;

   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_GROUPS = 8'h08;
   localparam logic [7:0] REG_RANG = 8'h0c;
   localparam logic [7:0] REG_USER = 8'h10;
   localparam logic [7:0] REG_SADDR = 8'h14;
   localparam logic [7:0] REG_SDATA = 8'h18;
   localparam logic [7:0] REG_CELL = 8'h1c;
   localparam logic [7:0] REG_LAST = 8'h20;
   localparam logic CTRL_RST = 1'b0;
   localparam int ST_ANT_ERR = 4;
   localparam int ST_FMT_ERR = 5;

   function automatic logic [15:0] sample_re(input logic [31:0] w);
      return w[15:0];
   endfunction : sample_re

   function automatic logic [15:0] sample_im(input logic [31:0] w);
      return w[31:16];
   endfunction : sample_im

   function automatic logic [6:0] fld7(input logic [40:0] w, input int lsb);
      return w[lsb +: 7];
   endfunction : fld7

   function automatic logic is_last(input logic [40:0] w);
      return w[HDR_LSB +: 2] == HDR_LAST;
   endfunction : is_last
endpackage : uds_pkg

// >>> rtl/uds_map_sink.sv
module uds_map_sink #(
   parameter int W = 41
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   input wire logic pop,
   output logic out_valid,
   output logic [W-1:0] out_word
);
   logic [W-1:0] e0_r, e0_nxt, e1_r, e1_nxt;
   logic [1:0] occ_r, occ_nxt;
   logic rdy_r, rdy_nxt;

   always_comb begin
      e0_nxt = e0_r;
      e1_nxt = e1_r;
      if (pop && occ_r == 2'd2) begin
         e0_nxt = e1_r;
         if (in_valid) e1_nxt = in_data;
      end else if ((pop && occ_r == 2'd1) || occ_r == 2'd0) begin
         if (in_valid) e0_nxt = in_data;
      end else if (in_valid) begin
         e1_nxt = in_data;
      end
      occ_nxt = occ_r + {1'b0, in_valid} - {1'b0, pop && occ_r != 2'd0};
      // latency one: a word may still arrive the cycle after ready falls
      rdy_nxt = (occ_nxt == 2'd0);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         e0_r <= '0;
         e1_r <= '0;
         occ_r <= 2'd0;
         rdy_r <= 1'b0;
      end else begin
         e0_r <= e0_nxt;
         e1_r <= e1_nxt;
         occ_r <= occ_nxt;
         rdy_r <= rdy_nxt;
      end
   end

   assign in_ready = rdy_r;
   assign out_valid = occ_r != 2'd0;
   assign out_word = e0_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_map_shift: assert property ((occ_r == 2'd2 && pop) |=> out_word == $past(e1_r))
      else $error("map word lost on shift");
   a_map_take: assert property ((occ_r == 2'd0 && in_valid) |=> out_valid && out_word == $past(in_data))
      else $error("map word not taken");
endmodule : uds_map_sink

// >>> rtl/uds_sample_store.sv
module uds_sample_store (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic din_valid,
   input wire logic [31:0] din_data,
   output logic din_ready,
   input wire logic release_grp,
   output logic group_ready,
   input wire logic [9:0] rd_addr,
   output logic [31:0] rd_data,
   output logic [31:0] last_sample
);
   logic [31:0] mem [0:767];
   logic [9:0] wptr_r, wptr_nxt;
   logic [10:0] count_r, count_nxt;
   logic rdy_r, rdy_nxt;
   logic [31:0] last_r, last_nxt;
   logic acc;

   always_comb begin
      // an idle input is ignored entirely
      acc = din_valid && count_r != uds_pkg::STORE_WORDS;
      wptr_nxt = wptr_r;
      last_nxt = last_r;
      if (acc) begin
         wptr_nxt = (wptr_r == uds_pkg::STORE_LAST) ? 10'd0 : wptr_r + 10'd1;
         last_nxt = {uds_pkg::sample_im(din_data), uds_pkg::sample_re(din_data)};
      end
      count_nxt = count_r + {10'd0, acc} - (release_grp ? uds_pkg::GROUP_WORDS : 11'd0);
      // two words of room: one may arrive while ready is seen low
      rdy_nxt = count_nxt <= uds_pkg::STORE_WORDS - 11'd2;
   end

   always_ff @(posedge pclk) begin
      if (acc) mem[wptr_r] <= din_data;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_r <= 10'd0;
         count_r <= 11'd0;
         rdy_r <= 1'b0;
         last_r <= 32'h0;
      end else begin
         wptr_r <= wptr_nxt;
         count_r <= count_nxt;
         rdy_r <= rdy_nxt;
         last_r <= last_nxt;
      end
   end

   assign din_ready = rdy_r;
   assign group_ready = count_r >= uds_pkg::GROUP_WORDS;
   assign rd_data = mem[rd_addr];
   assign last_sample = last_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_sample_write: assert property (acc |=> mem[$past(wptr_r)] == $past(din_data))
      else $error("sample not stored");
   a_idle_ignored: assert property ((!din_valid && !release_grp) |=> count_r == $past(count_r))
      else $error("idle input changed store");
   a_ready_room: assert property (rdy_r |-> count_r <= uds_pkg::STORE_WORDS - 11'd2)
      else $error("ready high without room");
endmodule : uds_sample_store

// >>> verification/uds_src_model.sv
module uds_src_model #(
   parameter int W = 32,
   parameter int GAP = 0
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic valid,
   output logic [W-1:0] data,
   input wire logic ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [W-1:0] q[$];
   initial begin
      valid = 1'b0;
      data = '0;
   end
   task automatic push(input logic [W-1:0] w);
      q.push_back(w);
   endtask : push
   // words leave in push order, only after ready was seen high, with random idle gaps only when GAP is above zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid <= 1'b0;
      end else if (ready === 1'b1 && q.size() > 0 && ($urandom % 4) >= GAP) begin
         valid <= 1'b1;
         data <= q.pop_front();
      end else begin
         valid <= 1'b0;
         data <= ~data;
      end
   end
endmodule : uds_src_model

// >>> verification/uds_top_bench.sv
module uds_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, din_valid, din_ready, rmapin_valid, rmapin_ready, dmapin_valid, dmapin_ready;
   logic [31:0] din_data;
   logic [40:0] rmapin_data;
   logic [34:0] dmapin_data;
   logic [6:0] cell_a = 7'h00;
   logic [6:0] cell_b = 7'h00;
   int n_errors = 0;
   int comparisons = 0;
   int taken = 0;
   logic [31:0] smp[$];

   always #50 pclk = ~pclk;
   always @(posedge pclk) if (presetn && din_valid === 1'b1) taken <= taken + 1;

   uds_top u_uds_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .din_valid(din_valid), .din_data(din_data), .din_ready(din_ready), .rmapin_valid(rmapin_valid),
      .rmapin_data(rmapin_data), .rmapin_ready(rmapin_ready), .dmapin_valid(dmapin_valid),
      .dmapin_data(dmapin_data), .dmapin_ready(dmapin_ready), .cell_identity_a(cell_a), .cell_identity_b(cell_b));
   uds_src_model #(.GAP(1)) u_din_src (.pclk(pclk), .presetn(presetn), .valid(din_valid),
      .data(din_data), .ready(din_ready));
   uds_src_model #(.W(41), .GAP(0)) u_rm_src (.pclk(pclk), .presetn(presetn), .valid(rmapin_valid),
      .data(rmapin_data), .ready(rmapin_ready));
   uds_src_model #(.W(35), .GAP(1)) u_um_src (.pclk(pclk), .presetn(presetn), .valid(dmapin_valid),
      .data(dmapin_data), .ready(dmapin_ready));

   task automatic summarize;
      $display("counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic timeout(input string what);
      n_errors++;
      $display("MISMATCH t=%0t wait for %s ran out", $time, what);
      summarize();
   endtask : timeout

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat,
                      output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) timeout("pready");
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic e;
      apb(1'b1, a, d, x, e);
      chk({31'h0, e}, 32'h0, "write error flag");
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic e;
      apb(1'b0, a, 32'h0, d, e);
      chk({31'h0, e}, 32'h0, "read error flag");
      chk(d & m, exp, what);
   endtask : rchk

   task automatic wait_groups(input int n);
      logic [31:0] d;
      logic e;
      int k;
      d = 32'h0;
      for (k = 0; k < 300 && d[15:0] !== n[15:0]; k++) apb(1'b0, uds_pkg::REG_GROUPS, 32'h0, d, e);
      if (d[15:0] !== n[15:0]) timeout("group count");
   endtask : wait_groups

   function automatic logic [40:0] rw(input logic [1:0] h, input logic [2:0] ant, input logic [3:0] ch,
                                      input logic [1:0] ty, input logic [6:0] f, input logic [15:0] slot);
      return {slot, 7'(f + 7'd3), f, ty, ch, ant, h};
   endfunction : rw

   function automatic logic [34:0] uw(input logic [1:0] h, input logic [2:0] ant, input logic [6:0] f,
                                      input logic [6:0] l, input logic [15:0] slot);
      return {slot, l, f, ant, h};
   endfunction : uw

   initial begin
      logic [31:0] d;
      logic e;
      logic [15:0] s0;
      int k;
      void'($urandom(848));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(uds_pkg::REG_CTRL, 32'h1, 32'h0, "ctrl reset");
      rchk(uds_pkg::REG_GROUPS, 32'hffff, 32'h0, "groups reset");
      apb(1'b1, 8'h24, 32'hffffffff, d, e);
      apb(1'b0, 8'h24, 32'h0, d, e);
      chk({31'h0, e}, 32'h1, "unmapped error flag");
      chk(d, 32'h0, "unmapped data");
      k = $urandom;
      cell_a <= 7'(k);
      cell_b <= 7'(k);
      repeat (2) @(posedge pclk);
      rchk(uds_pkg::REG_CELL, 32'hffff, {17'h0, cell_b, 1'b0, cell_a}, "cell same");
      cell_b <= cell_a ^ 7'h01;
      repeat (2) @(posedge pclk);
      rchk(uds_pkg::REG_CELL, 32'h8000, 32'h8000, "cell mismatch");
      $display("test registers done");
      for (int i = 0; i < 1152; i++) begin
         smp.push_back($urandom);
         u_din_src.push(smp[i]);
      end
      for (k = 0; k < 5000 && din_ready !== 1'b0; k++) @(posedge pclk);
      if (din_ready !== 1'b0) timeout("store full");
      repeat (4) @(posedge pclk);
      chk({31'h0, taken >= 767 && taken <= 768}, 32'h1, "words taken when full");
      rchk(uds_pkg::REG_STATUS, 32'h33, 32'h2, "status full");
      wr(uds_pkg::REG_SADDR, 32'd383);
      rchk(uds_pkg::REG_SDATA, 32'hffffffff, smp[383], "stored word");
      rchk(uds_pkg::REG_LAST, 32'h0000ffff, {16'h0, smp[taken-1][15:0]}, "last real");
      rchk(uds_pkg::REG_LAST, 32'hffff0000, {smp[taken-1][31:16], 16'h0}, "last imag");
      $display("test sample stream done");
      wr(uds_pkg::REG_CTRL, 32'h1);
      repeat (40) @(posedge pclk);
      rchk(uds_pkg::REG_GROUPS, 32'hffff, 32'h0, "waits for maps");
      s0 = 16'($urandom);
      for (int i = 0; i < 4; i++) u_rm_src.push(rw(i == 3 ? 2'h3 : 2'(i), 3'h2, 4'(i), 2'(i), 7'(4 * i),
         s0 + 16'(24 * i)));
      u_um_src.push(uw(2'h0, 3'h2, 7'd2, 7'd4, s0));
      u_um_src.push(uw(2'h3, 3'h2, 7'd10, 7'd10, s0 + 16'd3));
      wait_groups(1);
      rchk(uds_pkg::REG_RANG, 32'hffff003f, {s0, 10'h0, 2'h3, 4'h4}, "ranging summary");
      rchk(uds_pkg::REG_USER, 32'hffff00ff, {s0, 8'h0, 8'((4 - 2 + 1) + 1)}, "user summary");
      rchk(uds_pkg::REG_STATUS, 32'h30, 32'h0, "no faults");
      $display("test group one done");
      u_rm_src.push(rw(2'h3, 3'h2, 4'h0, 2'h0, 7'h7f, 16'h0));
      u_um_src.push(uw(2'h3, 3'h2, 7'h7f, 7'h7f, 16'h0));
      wait_groups(2);
      rchk(uds_pkg::REG_RANG, 32'hf, 32'h0, "no ranging");
      rchk(uds_pkg::REG_USER, 32'hff, 32'h0, "no user");
      $display("test empty group done");
      // antenna changes inside a packet and a reversed user range, both on purpose
      u_rm_src.push(rw(2'h0, 3'h1, 4'h0, 2'h2, 7'd8, 16'h5));
      u_rm_src.push(rw(2'h3, 3'h2, 4'h1, 2'h2, 7'd12, 16'h9));
      u_um_src.push(uw(2'h3, 3'h1, 7'd5, 7'd4, 16'h1));
      wait_groups(3);
      rchk(uds_pkg::REG_STATUS, 32'h30, 32'h30, "faults flagged");
      wr(uds_pkg::REG_STATUS, 32'h30);
      rchk(uds_pkg::REG_STATUS, 32'h30, 32'h0, "faults cleared");
      repeat (20) @(posedge pclk);
      chk(32'(taken), 32'd1152, "all words taken");
      $display("test faulty group done");
      summarize();
   end
endmodule : uds_top_bench
